// >>> rtl/aux_port.sv
/*
 * Auxiliary control port: six falling-edge inputs with optional debounce,
 * mapped to keys or preset recall; two active-low outputs and a pen-lift output; AXI4-Lite
 * registers with a sticky interrupt.
 * Assumes one 10 MHz clock and inputs from pins.
 */
`timescale 1ns/1ps
`include "aux_defines.svh"

module aux_port
   import aux_pkg::*;
#(
   parameter int DEB_CYC   = `AUX_DEB_CYC,
   parameter int PULSE_CYC = `AUX_PULSE_CYC
)(
   input  wire logic        aclk,           // 10 MHz clock
   input  wire logic        aresetn,        // synchronous reset
   input  wire logic [5:0]  aux_in_n,       // pins 2..7, asynchronous
   input  wire logic        sweep_done,     // one-cycle pulse, sweep finished
   input  wire logic        param_changed,  // one-cycle pulse, parameter changed
   input  wire logic        err53,          // one-cycle pulse, memory check code 53
   output aux_cmd_t         cmd,            // one-cycle action pulses
   output logic             sweep_end_n,    // pin 1, low pulse
   output logic             pen_lift,       // pin 9
   output logic             param_out_n,    // pin 12
   output logic             irq,            // level interrupt
   input  wire logic [7:0]  s_axi_awaddr,   // write address
   input  wire logic        s_axi_awvalid,  // write address valid
   output logic             s_axi_awready,  // write address ready
   input  wire logic [31:0] s_axi_wdata,    // write data
   input  wire logic [3:0]  s_axi_wstrb,    // byte enables
   input  wire logic        s_axi_wvalid,   // write data valid
   output logic             s_axi_wready,   // write data ready
   output logic [1:0]       s_axi_bresp,    // write response
   output logic             s_axi_bvalid,   // write response valid
   input  wire logic        s_axi_bready,   // write response ready
   input  wire logic [7:0]  s_axi_araddr,   // read address
   input  wire logic        s_axi_arvalid,  // read address valid
   output logic             s_axi_arready,  // read address ready
   output logic [31:0]      s_axi_rdata,    // read data
   output logic [1:0]       s_axi_rresp,    // read response
   output logic             s_axi_rvalid,   // read data valid
   input  wire logic        s_axi_rready    // read data ready
);

   // refuse counts that would overflow the counters below
   localparam bit CFG_BAD = DEB_CYC < 1 || DEB_CYC > 1048575 || PULSE_CYC < 1
                            || PULSE_CYC > 65535;
   generate
      if (CFG_BAD) begin : g_bad_cfg
         $error("aux_port: counts out of range");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [31:0] ctrl_reg;
   logic [2:0]  irq_stat_reg;
   logic [2:0]  irq_en_reg;
   logic [7:0]  aw_reg;
   logic        aw_ok_reg;
   logic [31:0] wd_reg;
   logic [3:0]  ws_reg;
   logic        wd_ok_reg;
   logic [2:0]  irq_clr;
   logic        wr_go;

   wire deb_on  = ctrl_reg[`AUX_CTRL_DEB_BIT];
   wire hop_on  = ctrl_reg[`AUX_CTRL_HOP_BIT];
   wire knob_on = ctrl_reg[`AUX_CTRL_KNOB_BIT];

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `AUX_CTRL_OFF) || (a == `AUX_STAT_OFF) || (a == `AUX_IRQ_STAT_OFF)
            || (a == `AUX_IRQ_EN_OFF) || (a == `AUX_IRQ_CLR_OFF) || (a == `AUX_EVT_OFF);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // input synchroniser, debounce and falling-edge detect

   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic [5:0] level_reg;
   logic [5:0] fall;

   // reset to ones, the idle level, so no false fall follows reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 6'h3f;
         sync2_reg <= 6'h3f;
      end else begin
         sync1_reg <= aux_in_n;
         sync2_reg <= sync1_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_line
         logic [19:0] deb_cnt_reg;
         // a line must stay at its new level for the whole window before it is believed
         // limitation: a line that toggles faster than the window is never believed
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               level_reg[g]   <= 1'b1;
               deb_cnt_reg    <= 20'h0_0000;
            end else if (!deb_on) begin
               level_reg[g]   <= sync2_reg[g];
               deb_cnt_reg    <= 20'h0_0000;
            end else if (sync2_reg[g] == level_reg[g]) begin
               deb_cnt_reg    <= 20'h0_0000;
            end else if (deb_cnt_reg >= 20'(DEB_CYC - 1)) begin
               level_reg[g]   <= sync2_reg[g];
               deb_cnt_reg    <= 20'h0_0000;
            end else begin
               deb_cnt_reg    <= deb_cnt_reg + 20'h0_0001;
            end
         end
         // decoded from the level about to be believed, so a fall costs no extra cycle
         assign fall[g] = level_reg[g] && !(deb_on ? (deb_cnt_reg >= 20'(DEB_CYC - 1)
                          && sync2_reg[g] != level_reg[g] ? sync2_reg[g] : 1'b1)
                          : sync2_reg[g]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // mapping of falls to actions

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd <= '0;
      end else begin
         // the default clear leaves only this cycle's falls, so each action lasts one cycle
         cmd          <= '0;
         // line reports every fall in both mappings
         cmd.line     <= fall;
         // hop mode claims all six lines, so key and sweep actions stay quiet
         if (hop_on) begin
            cmd.jump  <= fall;
         end else begin
            // knob and step share pins 2 and 3; the knob function picks one
            cmd.up       <= fall[0] && !knob_on;
            cmd.down     <= fall[1] && !knob_on;
            cmd.knob_cw  <= fall[0] && knob_on;
            cmd.knob_ccw <= fall[1] && knob_on;
            cmd.manual   <= fall[2];
            cmd.auto_swp <= fall[3];
            cmd.single   <= fall[4];
            cmd.advance  <= fall[5];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // pulse counters hold the cycles left after the current one
   logic [15:0]   sw_cnt_reg;
   logic [15:0]   po_cnt_reg;
   aux_po_state_t po_state_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_cnt_reg  <= 16'h0000;
         sweep_end_n <= 1'b1;
      end else if (sweep_done) begin
         // a sweep end inside a pulse restarts the window, so pulses may merge
         sw_cnt_reg  <= 16'(PULSE_CYC - 1);
         sweep_end_n <= 1'b0;
      end else if (sw_cnt_reg != 16'h0000) begin
         sw_cnt_reg  <= sw_cnt_reg - 16'h0001;
      end else begin
         sweep_end_n <= 1'b1;
      end
   end

   // a change while latched only releases the line; it does not also pulse
   // err53 outranks a change in the same cycle, so the latch is never missed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         po_state_reg <= AUX_PO_IDLE;
         po_cnt_reg   <= 16'h0000;
         param_out_n  <= 1'b1;
      end else if (err53) begin
         po_state_reg <= AUX_PO_LATCH;
         param_out_n  <= 1'b0;
      end else begin
         unique case (po_state_reg)
            AUX_PO_IDLE: begin
               if (param_changed) begin
                  po_state_reg <= AUX_PO_PULSE;
                  po_cnt_reg   <= 16'(PULSE_CYC - 1);
                  param_out_n  <= 1'b0;
               end
            end
            AUX_PO_PULSE: begin
               if (param_changed) begin
                  po_cnt_reg   <= 16'(PULSE_CYC - 1);
               end else if (po_cnt_reg != 16'h0000) begin
                  po_cnt_reg   <= po_cnt_reg - 16'h0001;
               end else begin
                  po_state_reg <= AUX_PO_IDLE;
                  param_out_n  <= 1'b1;
               end
            end
            AUX_PO_LATCH: begin
               if (param_changed) begin
                  po_state_reg <= AUX_PO_IDLE;
                  param_out_n  <= 1'b1;
               end
            end
            default: begin
               po_state_reg <= AUX_PO_IDLE;
               param_out_n  <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pen_lift <= 1'b1;
      end else begin
         // outside single sweep the pen output rests high
         pen_lift <= ctrl_reg[`AUX_CTRL_SINGLE_BIT] ? ctrl_reg[`AUX_CTRL_PEN_UP_BIT]
                     : 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt

   // same-clock event pulses; a clear in the same cycle loses to them
   wire [2:0] events = {err53, param_changed, sweep_done};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_reg <= 3'h0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | events;  // set wins
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave

   // aw and w may come in either order; the write acts once both halves are held
   // no new half is taken until the response has been accepted
   assign s_axi_awready = !aw_ok_reg && !s_axi_bvalid;
   assign s_axi_wready  = !wd_ok_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go         = aw_ok_reg && wd_ok_reg;
   assign irq_clr       = (wr_go && aw_reg == `AUX_IRQ_CLR_OFF && ws_reg[0]) ? wd_reg[2:0]
                          : 3'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_reg    <= 1'b0;
         wd_ok_reg    <= 1'b0;
         aw_reg       <= 8'h00;
         wd_reg       <= 32'h0000_0000;
         ws_reg       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_reg <= 1'b1;
            aw_reg    <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd_ok_reg <= 1'b1;
            wd_reg    <= s_axi_wdata;
            ws_reg    <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_ok_reg    <= 1'b0;
            wd_ok_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // unmapped offsets answer slverr and change nothing
            s_axi_bresp  <= mapped(aw_reg) ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg   <= `AUX_CTRL_RESET;
         irq_en_reg <= 3'h0;
      end else if (wr_go && aw_reg == `AUX_CTRL_OFF) begin
         // only the five defined bits are kept; the rest read back zero
         ctrl_reg   <= merge(ctrl_reg, wd_reg, ws_reg) & 32'h0000_001f;
      end else if (wr_go && aw_reg == `AUX_IRQ_EN_OFF && ws_reg[0]) begin
         irq_en_reg <= wd_reg[2:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
         unique case (s_axi_araddr)
            `AUX_CTRL_OFF:     s_axi_rdata <= ctrl_reg;
            // status: po_state, pen_lift, param_out_n, sweep_end_n, a zero, filtered levels
            `AUX_STAT_OFF:     s_axi_rdata <= {20'h0_0000, po_state_reg, pen_lift,
                                               param_out_n, sweep_end_n, 1'b0, level_reg};
            `AUX_IRQ_STAT_OFF: s_axi_rdata <= {29'h0, irq_stat_reg};
            `AUX_IRQ_EN_OFF:   s_axi_rdata <= {29'h0, irq_en_reg};
            default:           s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// >>> rtl/aux_defines.svh
/*
 * Constants of the auxiliary control port: register offsets, field positions,
 * reset values and timing counts.
 * Assumes the including file runs on a 10 MHz clock.
 */
`ifndef AUX_DEFINES_SVH
`define AUX_DEFINES_SVH

`define AUX_CLK_HZ          10000000
`define AUX_PULSE_NS        5000
`define AUX_PULSE_CYC       ((`AUX_PULSE_NS * (`AUX_CLK_HZ / 1000000)) / 1000)
`define AUX_DEB_CYC         100000
`define AUX_SPACING_NS      5000

`define AUX_CTRL_OFF        8'h00
`define AUX_STAT_OFF        8'h04
`define AUX_IRQ_STAT_OFF    8'h08
`define AUX_IRQ_EN_OFF      8'h0c
`define AUX_IRQ_CLR_OFF     8'h10
`define AUX_EVT_OFF         8'h14

`define AUX_CTRL_DEB_BIT    0
`define AUX_CTRL_HOP_BIT    1
`define AUX_CTRL_KNOB_BIT   2
`define AUX_CTRL_SINGLE_BIT 3
`define AUX_CTRL_PEN_UP_BIT 4
`define AUX_CTRL_RESET      32'h0000_0000

`define AUX_EVT_SWEEP_BIT   0
`define AUX_EVT_PARAM_BIT   1
`define AUX_EVT_ERR53_BIT   2

`endif

// >>> rtl/aux_pkg.sv
/*
 * Types of the auxiliary control port.
 * Assumes aux_defines.svh is included by the user.
 */
package aux_pkg;

   typedef enum logic [3:0] {
      AUX_ACT_NONE      = 4'h0,
      AUX_ACT_STEP_UP   = 4'h1,
      AUX_ACT_STEP_DOWN = 4'h2,
      AUX_ACT_KNOB_CW   = 4'h3,
      AUX_ACT_KNOB_CCW  = 4'h4,
      AUX_ACT_MANUAL    = 4'h5,
      AUX_ACT_AUTO      = 4'h6,
      AUX_ACT_SINGLE    = 4'h7,
      AUX_ACT_ADVANCE   = 4'h8,
      AUX_ACT_JUMP      = 4'h9
   } aux_action_t;

   typedef struct packed {
      logic [5:0] line;   // one bit per input that fell
      logic [5:0] jump;   // preset recall, one bit per line that fell
      logic       up;
      logic       down;
      logic       knob_cw;
      logic       knob_ccw;
      logic       manual;
      logic       auto_swp;
      logic       single;
      logic       advance;
   } aux_cmd_t;

   typedef enum logic [1:0] {
      AUX_PO_IDLE  = 2'b00,
      AUX_PO_PULSE = 2'b01,
      AUX_PO_LATCH = 2'b11
   } aux_po_state_t;

endpackage

// >>> sim/aux_port_monitor.sv
/* Checker of the auxiliary port: output pulses, latch, action pulses.
   Assumes it is bound into aux_port and given its PULSE_CYC. */
`timescale 1ns/1ps
module aux_port_monitor
   import aux_pkg::*;
#(
   parameter int PULSE_CYC = 50
)(
   input wire logic       aclk,          // clock
   input wire logic       aresetn,       // sync reset
   input wire logic [5:0] aux_in_n,      // input pins
   input wire logic       sweep_done,    // sweep event
   input wire logic       param_changed, // parameter event
   input wire logic       err53,         // memory error event
   input wire aux_cmd_t   cmd,           // action pulses
   input wire logic       sweep_end_n,   // sweep end out
   input wire logic       param_out_n    // parameter out
);
////////////////////////////////////////////////////////////////////////////////
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);

logic [7:0] se_cnt;
logic [7:0] po_cnt;
logic       lat;

// low-run lengths, so pulse widths up to 255 cycles are measured exactly
always_ff @(posedge aclk) begin
   se_cnt <= (!aresetn || sweep_end_n) ? 8'h00 : se_cnt + 8'h01;
   po_cnt <= (!aresetn || param_out_n) ? 8'h00 : po_cnt + 8'h01;
end

always_ff @(posedge aclk) begin
   if (!aresetn || (param_changed && !err53)) begin
      lat <= 1'h0;
   end else if (err53) begin
      lat <= 1'h1;
   end
end

sequence sweep_low_s;
   !sweep_end_n;
endsequence

sequence param_low_s;
   !param_out_n;
endsequence
////////////////////////////////////////////////////////////////////////////////
sweep_start_a: assert property (sweep_done |=> sweep_low_s)
   else $error("sweep end pulse missing");
sweep_len_a: assert property ($rose(sweep_end_n) |-> se_cnt == PULSE_CYC)
   else $error("sweep end pulse width wrong");
sweep_rest_a: assert property ($fell(sweep_end_n) |-> $past(sweep_done))
   else $error("sweep end fell without cause");
param_rest_a: assert property ($fell(param_out_n) |-> $past(param_changed) || $past(err53))
   else $error("parameter out fell without cause");
param_pulse_a: assert property (param_changed && !lat && !err53 |=> param_low_s)
   else $error("parameter pulse missing");
param_len_a: assert property ($rose(param_out_n) && !$past(param_changed)
   |-> po_cnt == PULSE_CYC)
   else $error("parameter pulse width wrong");
err_hold_a: assert property ((err53 || lat) && !param_changed |=> param_low_s)
   else $error("latched low lost");
latch_free_a: assert property (lat && param_changed && !err53 |=> param_out_n)
   else $error("latched low not released");
pin_cause_a: assert property (|cmd.line |-> (cmd.line & $past(aux_in_n, 2)) == 6'h00)
   else $error("action without low pin");
act_once_a: assert property (|cmd.line |=> (cmd.line & $past(cmd.line)) == 6'h00)
   else $error("action longer than one cycle");
jump_map_a: assert property (|cmd.jump |-> cmd.jump == cmd.line)
   else $error("preset recall on wrong line");
step_map_a: assert property (cmd.up || cmd.knob_cw |-> cmd.line == 6'h01)
   else $error("step up on wrong line");
endmodule

bind aux_port aux_port_monitor #(.PULSE_CYC(PULSE_CYC)) mon (
   .aclk, .aresetn, .aux_in_n, .sweep_done, .param_changed, .err53, .cmd,
   .sweep_end_n, .param_out_n
);

// >>> sim/aux_sw_model.sv
/* Outside switch or TTL driver on the six input pins.
   Assumes the bench calls press() from one process at a time. */
`timescale 1ns/1ps
module aux_sw_model (
   input wire logic  aclk,     // clock
   output logic [5:0] aux_in_n // input pins, idle high
);
initial aux_in_n = 6'h3f;

// bounces stay far shorter than the debounce filter
task automatic press(input int i, input bit b);
   if (b) begin
      repeat (3) begin
         @(posedge aclk);
         aux_in_n[i] <= 1'h0;
         @(posedge aclk);
         aux_in_n[i] <= 1'h1;
      end
   end
   @(posedge aclk);
   aux_in_n[i] <= 1'h0;
   repeat (60) @(posedge aclk);
   aux_in_n[i] <= 1'h1;
   repeat (60) @(posedge aclk);
endtask
endmodule

// >>> sim/test_aux_port.sv
/* Self-checking bench of aux_port: pins through a switch model, bus by AXI4-Lite.
   Assumes a 10 MHz clock and a short debounce count. */
`timescale 1ns/1ps
`include "aux_defines.svh"
module test_aux_port
   import aux_pkg::*;
;
logic        aclk = 1'h0, aresetn = 1'h0;
logic        sweep_done = 1'h0, param_changed = 1'h0, err53 = 1'h0;
logic [5:0]  aux_in_n;
aux_cmd_t    cmd;
logic        sweep_end_n, pen_lift, param_out_n, irq;
logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0]  s_axi_bresp, s_axi_rresp;
logic [31:0] exp_q[$];
int          err_count = 0, checks = 0;

always #50 aclk = ~aclk;

aux_sw_model sw (.aclk, .aux_in_n);

aux_port #(.DEB_CYC(8), .PULSE_CYC(50)) dut (
   .aclk, .aresetn, .aux_in_n, .sweep_done, .param_changed, .err53, .cmd,
   .sweep_end_n, .pen_lift, .param_out_n, .irq, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] v, input logic [31:0] e);
   checks++;
   if (v !== e) begin
      err_count++;
      $display("BAD t=%0t got %h expected %h", $time, v, e);
   end
endtask

task automatic summarize();
   $display("checks=%0d err_count=%0d", checks, err_count);
   if (err_count == 0 && checks > 0) $display("TB: PASS");
   else $display("TB: FAIL");
   $finish;
endtask

// an empty queue yields x, so an unexpected result never matches
function automatic logic [31:0] nxt();
   return exp_q.size() ? exp_q.pop_front() : 32'hx;
endfunction

function automatic logic [31:0] ecmd(int i, int m);
   aux_cmd_t e;
   e = '0;
   e.line[i] = 1'h1;
   if (m == 2) e.jump[i] = 1'h1;
   else if (m == 1 && i < 2) {e.knob_cw, e.knob_ccw} = 2'h2 >> i;
   else {e.up, e.down, e.manual, e.auto_swp, e.single, e.advance} = 6'h20 >> i;
   return 32'(e);
endfunction

task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
   exp_q.push_back(32'(r));
   @(posedge aclk);
   {s_axi_awaddr, s_axi_wdata} <= {a, d};
   {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
   do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
   end while (!s_axi_bvalid);
   s_axi_bready <= 1'h0;
   @(posedge aclk);
endtask

task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
   exp_q.push_back(32'(r));
   exp_q.push_back(e);
   @(posedge aclk);
   s_axi_araddr <= a;
   {s_axi_arvalid, s_axi_rready} <= 2'h3;
   do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
   end while (!s_axi_rvalid);
   s_axi_rready <= 1'h0;
endtask

task automatic hit(input int i, input int m, input bit b);
   exp_q.push_back(ecmd(i, m));
   sw.press(i, b);
endtask

task automatic ev(input logic [2:0] v);
   @(posedge aclk);
   {sweep_done, param_changed, err53} <= v;
   @(posedge aclk);
   {sweep_done, param_changed, err53} <= 3'h0;
   @(posedge aclk);
endtask
////////////////////////////////////////////////////////////////////////////////
always @(posedge aclk) begin
   if (|cmd.line) chk(32'(cmd), nxt());
   if (s_axi_bvalid && s_axi_bready) chk(32'(s_axi_bresp), nxt());
   if (s_axi_rvalid && s_axi_rready) chk(32'(s_axi_rresp), nxt());
   if (s_axi_rvalid && s_axi_rready) chk(s_axi_rdata, nxt());
end

initial begin
   repeat (30000) @(posedge aclk);
   err_count++;
   summarize();
end

initial begin
   void'($urandom(81575));
   repeat (5) @(posedge aclk);
   aresetn <= 1'h1;
   rd(`AUX_CTRL_OFF, `AUX_CTRL_RESET);
   chk(32'({sweep_end_n, param_out_n, pen_lift, irq}), 32'he);
   for (int i = 0; i < 6; i++) hit(i, 0, 0);
   wr(`AUX_CTRL_OFF, 32'h4);
   hit(0, 1, 0);
   hit(1, 1, 0);
   wr(`AUX_CTRL_OFF, 32'h2);
   for (int i = 0; i < 6; i++) hit(i, 2, 0);
   wr(`AUX_CTRL_OFF, 32'h1);
   repeat (3) hit($urandom % 6, 0, 1);
   wr(`AUX_CTRL_OFF, 32'h8);
   chk(32'(pen_lift), 32'h0);
   wr(`AUX_CTRL_OFF, 32'h18);
   chk(32'(pen_lift), 32'h1);
   wr(`AUX_IRQ_EN_OFF, 32'h1);
   ev(3'h4);
   chk(32'({sweep_end_n, irq}), 32'h1);
   repeat (55) @(posedge aclk);
   chk(32'(sweep_end_n), 32'h1);
   rd(`AUX_IRQ_STAT_OFF, 32'h1);
   wr(`AUX_IRQ_EN_OFF, 32'h0);
   chk(32'(irq), 32'h0);
   wr(`AUX_IRQ_CLR_OFF, 32'h1);
   rd(`AUX_IRQ_STAT_OFF, 32'h0);
   ev(3'h2);
   chk(32'(param_out_n), 32'h0);
   repeat (55) @(posedge aclk);
   chk(32'(param_out_n), 32'h1);
   ev(3'h1);
   repeat (80) @(posedge aclk);
   chk(32'(param_out_n), 32'h0);
   ev(3'h2);
   chk(32'(param_out_n), 32'h1);
   rd(8'h40, 32'h0, 2'h2);
   wr(8'h40, 32'h1, 2'h2);
   chk(32'(exp_q.size()), 32'h0);
   summarize();
end
endmodule
